// ===== mbd_top.sv
// Bank decoder, address pin generator, endian lane steering and register file
module mbd_top
   import mbd_pkg::*;
(
   input  wire logic                 CLK_IN,
   input  wire logic                 RESET_N_IN,
   input  wire logic                 REQ_IN,
   input  wire logic                 REQ_WRITE_IN,
   input  wire logic [31:0]          REQ_ADDR_IN,
   input  wire logic [31:0]          REQ_WDATA_IN,
   output logic                      BUSY_OUT,
   output logic                      DONE_OUT,
   output logic                      ABORT_OUT,
   output logic [31:0]               RDATA_OUT,
   output logic                      CACHEABLE_OUT,
   output logic                      PERIPH_SEL_OUT,
   output logic                      RAM_SEL_OUT,
   input  wire logic [7:0]           REG_ADDR_IN,
   input  wire logic [31:0]          REG_WDATA_IN,
   input  wire logic                 REG_WR_IN,
   input  wire logic                 REG_RD_IN,
   output logic [31:0]               REG_RDATA_OUT,
   output logic                      IRQ_OUT,
   input  wire logic                 ENDIAN_STRAP_DATA_LINE_IN,
   output logic [24:0]               EXT_ADDR_OUT,
   output logic [31:0]               EXT_WDATA_OUT,
   output logic                      EXT_DATA_OE_N_OUT,
   input  wire logic [31:0]          EXT_RDATA_IN,
   output logic [3:0]                EXT_BE_N_OUT,
   output logic [NUM_BANKS-1:0]      EXT_CS_OUT,
   output logic                      EXT_WR_OUT,
   output logic                      EXT_RD_OUT
);
   // Synchronisers and strap capture
   logic        strap_s1;
   logic        strap_s2;
   logic [31:0] rd_s1;
   logic [31:0] rd_s2;
   logic [1:0]  strap_cnt;
   logic [1:0]  next_strap_cnt;
   logic        little;
   logic        next_little;
   logic        ready;
   logic        next_ready;

   // Register file
   logic [31:0]         bank [NUM_BANKS];
   logic [31:0]         next_bank [NUM_BANKS];
   logic [STAT_W-1:0]   status;
   logic [STAT_W-1:0]   next_status;
   logic [STAT_W-1:0]   mask;
   logic [STAT_W-1:0]   next_mask;
   logic [31:0]         next_reg_rdata;
   logic                next_irq;

   // Sequencer
   mbd_state_t                state;
   mbd_state_t                next_state;
   logic [31:0]               addr;
   logic [31:0]               next_addr;
   logic [31:0]               wdata;
   logic [31:0]               next_wdata;
   logic [31:0]               accum;
   logic [31:0]               next_accum;
   logic                      wr;
   logic                      next_wr;
   logic [1:0]                width;
   logic [1:0]                next_width;
   logic [1:0]                beat;
   logic [1:0]                next_beat;
   logic [1:0]                timer;
   logic [1:0]                next_timer;
   logic [NUM_BANKS-1:0]      sel;
   logic [NUM_BANKS-1:0]      next_sel;
   logic                      next_done;
   logic                      next_abort;
   logic [31:0]               next_rdata;
   logic                      next_cacheable;
   logic                      next_periph;
   logic                      next_ram;
   logic [24:0]               next_ext_addr;
   logic [31:0]               next_ext_wdata;
   logic                      next_oe_n;
   logic [3:0]                next_be_n;
   logic [NUM_BANKS-1:0]      next_cs;
   logic                      next_ext_wr;
   logic                      next_ext_rd;
   logic [STAT_W-1:0]         events;

   // Decode
   logic [NUM_BANKS-1:0] hit;
   logic [NUM_BANKS-1:0] first_hit;
   logic [1:0]           bank_width [NUM_BANKS];
   logic                 in_window;
   logic                 fixed_periph;
   logic                 fixed_ram;
   logic [31:0]          merged;

   // Strap and read data pass two flops before use
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
         rd_s1    <= 32'h0000_0000;
         rd_s2    <= 32'h0000_0000;
      end else begin
         strap_s1 <= ENDIAN_STRAP_DATA_LINE_IN;
         strap_s2 <= strap_s1;
         rd_s1    <= EXT_RDATA_IN;
         rd_s2    <= rd_s1;
      end
   end

   // Strap is caught once the synchroniser has settled after release
   always_comb begin
      next_strap_cnt = strap_cnt;
      next_little    = little;
      next_ready     = ready;
      if (!ready) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt == STRAP_CAPTURE_CYCLE) begin
            next_little = strap_s2;
            next_ready  = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         strap_cnt <= 2'h0;
         little    <= 1'b0;
         ready     <= 1'b0;
      end else begin
         strap_cnt <= next_strap_cnt;
         little    <= next_little;
         ready     <= next_ready;
      end
   end

   // Per-bank hit from base pointer and clamped size
   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
         logic [31:0] base;
         logic [31:0] offs;
         logic [3:0]  size;
         logic [1:0]  wcode;
         always_comb begin
            base = {bank[gb][BASE_LSB +: BASE_W], 19'h0_0000} >> (BASE_LSB - BASE_SHIFT);
            offs = REQ_ADDR_IN - base;
            size = bank[gb][SIZE_LSB +: 4];
            if (bank[gb][SDRAM_BIT] && size > SIZE_MAX_SDRAM) begin
               size = SIZE_MAX_SDRAM;
            end else if (!bank[gb][SDRAM_BIT] && size > SIZE_MAX_IO) begin
               size = SIZE_MAX_IO;
            end
            wcode = bank[gb][WIDTH_LSB +: 2];
            if (wcode > WIDTH_32) begin
               wcode = WIDTH_32;
            end
            bank_width[gb] = wcode;
            hit[gb] = bank[gb][ENABLE_BIT] && ((offs[31:BASE_SHIFT] >> size) == 14'h0000)
                      && REQ_ADDR_IN >= base;
         end
      end
   endgenerate

   // Region checks and lowest-numbered hit
   always_comb begin
      fixed_periph = REQ_ADDR_IN >= PERIPH_BASE;
      fixed_ram    = REQ_ADDR_IN >= RAM_BASE && !fixed_periph;
      in_window    = REQ_ADDR_IN <= CACHE_TOP ||
                     (REQ_ADDR_IN >= NC_BASE && REQ_ADDR_IN <= NC_TOP);
      first_hit    = hit & (~hit + NUM_BANKS'(1));
   end

   mbd_lane_map u_merge (
      .word_in    (accum),
      .ext_in     (rd_s2),
      .beat_in    (beat),
      .width_in   (width),
      .little_in  (little),
      .ext_out    (),
      .merged_out (merged)
   );

   // Sequencer next state and request result outputs
   always_comb begin
      next_state     = state;
      next_addr      = addr;
      next_wdata     = wdata;
      next_accum     = accum;
      next_wr        = wr;
      next_width     = width;
      next_beat      = beat;
      next_timer     = timer;
      next_sel       = sel;
      next_done      = 1'b0;
      next_abort     = 1'b0;
      next_rdata     = RDATA_OUT;
      next_cacheable = CACHEABLE_OUT;
      next_periph    = PERIPH_SEL_OUT;
      next_ram       = RAM_SEL_OUT;
      events         = '0;
      case (state)
         ST_IDLE: begin
            if (REQ_IN && ready) begin
               next_cacheable = !REQ_ADDR_IN[31];
               next_periph    = fixed_periph;
               next_ram       = fixed_ram;
               next_addr      = REQ_ADDR_IN;
               next_wdata     = REQ_WDATA_IN;
               next_wr        = REQ_WRITE_IN;
               next_accum     = 32'h0000_0000;
               if (fixed_periph || fixed_ram) begin
                  next_done  = 1'b1;
                  next_rdata = 32'h0000_0000;
               end else if (in_window && hit != '0) begin
                  next_sel   = first_hit;
                  next_beat  = 2'h0;
                  next_timer = 2'h0;
                  next_state = ST_BEAT;
                  for (int i = 0; i < NUM_BANKS; i++) begin
                     if (first_hit[i]) begin
                        next_width = bank_width[i];
                     end
                  end
                  events[STAT_OVERLAP] = first_hit != hit;
               end else begin
                  next_abort          = 1'b1;
                  next_done           = 1'b1;
                  next_rdata          = 32'h0000_0000;
                  events[STAT_ABORT]  = 1'b1;
               end
            end
         end
         ST_BEAT: begin
            next_timer = timer + 2'h1;
            if (timer == BEAT_HOLD_CYCLES - 2'h1) begin
               next_timer = 2'h0;
               next_accum = merged;
               if (beat == 2'((3'(4) >> width) - 3'(1))) begin
                  next_state        = ST_IDLE;
                  next_sel          = '0;
                  next_done         = 1'b1;
                  next_rdata        = wr ? 32'h0000_0000 : merged;
                  events[STAT_DONE] = 1'b1;
               end else begin
                  next_beat = beat + 2'h1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   logic [31:0] next_beat_addr;
   mbd_lane_map u_drive (
      .word_in    (next_wdata),
      .ext_in     (32'h0000_0000),
      .beat_in    (next_beat),
      .width_in   (next_width),
      .little_in  (little),
      .ext_out    (next_ext_wdata),
      .merged_out ()
   );

   // External pins for the beat that the next cycle shows
   always_comb begin
      next_beat_addr = {next_addr[31:2], 2'b00} + 32'(next_beat << next_width);
      next_ext_addr  = 25'h000_0000;
      next_be_n      = 4'hF;
      next_cs        = '0;
      next_ext_wr    = 1'b0;
      next_ext_rd    = 1'b0;
      next_oe_n      = 1'b1;
      if (next_state == ST_BEAT) begin
         next_cs     = next_sel;
         next_ext_wr = next_wr;
         next_ext_rd = !next_wr;
         next_oe_n   = !next_wr;
         case (next_width)
            WIDTH_8: begin
               next_ext_addr = next_beat_addr[24:0];
               next_be_n     = 4'hE;
            end
            WIDTH_16: begin
               next_ext_addr = {1'b0, next_beat_addr[24:1]};
               next_be_n     = 4'hC;
            end
            default: begin
               next_ext_addr = {2'b00, next_beat_addr[24:2]};
               next_be_n     = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state             <= ST_IDLE;
         addr              <= 32'h0000_0000;
         wdata             <= 32'h0000_0000;
         accum             <= 32'h0000_0000;
         wr                <= 1'b0;
         width             <= WIDTH_32;
         beat              <= 2'h0;
         timer             <= 2'h0;
         sel               <= '0;
         BUSY_OUT          <= 1'b1;
         DONE_OUT          <= 1'b0;
         ABORT_OUT         <= 1'b0;
         RDATA_OUT         <= 32'h0000_0000;
         CACHEABLE_OUT     <= 1'b0;
         PERIPH_SEL_OUT    <= 1'b0;
         RAM_SEL_OUT       <= 1'b0;
         EXT_ADDR_OUT      <= 25'h000_0000;
         EXT_WDATA_OUT     <= 32'h0000_0000;
         EXT_DATA_OE_N_OUT <= 1'b1;
         EXT_BE_N_OUT      <= 4'hF;
         EXT_CS_OUT        <= '0;
         EXT_WR_OUT        <= 1'b0;
         EXT_RD_OUT        <= 1'b0;
      end else begin
         state             <= next_state;
         addr              <= next_addr;
         wdata             <= next_wdata;
         accum             <= next_accum;
         wr                <= next_wr;
         width             <= next_width;
         beat              <= next_beat;
         timer             <= next_timer;
         sel               <= next_sel;
         BUSY_OUT          <= next_state == ST_BEAT || !next_ready;
         DONE_OUT          <= next_done;
         ABORT_OUT         <= next_abort;
         RDATA_OUT         <= next_rdata;
         CACHEABLE_OUT     <= next_cacheable;
         PERIPH_SEL_OUT    <= next_periph;
         RAM_SEL_OUT       <= next_ram;
         EXT_ADDR_OUT      <= next_ext_addr;
         EXT_WDATA_OUT     <= next_ext_wdata;
         EXT_DATA_OE_N_OUT <= next_oe_n;
         EXT_BE_N_OUT      <= next_be_n;
         EXT_CS_OUT        <= next_cs;
         EXT_WR_OUT        <= next_ext_wr;
         EXT_RD_OUT        <= next_ext_rd;
      end
   end

   // Register writes, sticky status and read mux
   always_comb begin
      next_bank      = bank;
      next_mask      = mask;
      next_status    = status;
      next_reg_rdata = 32'h0000_0000;
      if (REG_WR_IN) begin
         if (REG_ADDR_IN == OFS_STATUS) begin
            next_status = status & ~REG_WDATA_IN[STAT_W-1:0];
         end
         if (REG_ADDR_IN == OFS_MASK) begin
            next_mask = REG_WDATA_IN[STAT_W-1:0];
         end
         for (int i = 0; i < NUM_BANKS; i++) begin
            if (REG_ADDR_IN == OFS_BANK0 + 8'(4 * i)) begin
               next_bank[i] = REG_WDATA_IN;
            end
         end
      end
      // Set wins over a same-cycle clear
      next_status = next_status | events;
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == OFS_STATUS) begin
            next_reg_rdata = 32'(status);
         end
         if (REG_ADDR_IN == OFS_MASK) begin
            next_reg_rdata = 32'(mask);
         end
         if (REG_ADDR_IN == OFS_INFO) begin
            next_reg_rdata = {29'h0000_0000, ready, state == ST_BEAT, little};
         end
         for (int i = 0; i < NUM_BANKS; i++) begin
            if (REG_ADDR_IN == OFS_BANK0 + 8'(4 * i)) begin
               next_reg_rdata = bank[i];
            end
         end
      end
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         for (int i = 0; i < NUM_BANKS; i++) begin
            bank[i] <= BANK_RESET;
         end
         status        <= '0;
         mask          <= MASK_RESET;
         REG_RDATA_OUT <= 32'h0000_0000;
         IRQ_OUT       <= 1'b0;
      end else begin
         bank          <= next_bank;
         status        <= next_status;
         mask          <= next_mask;
         REG_RDATA_OUT <= next_reg_rdata;
         IRQ_OUT       <= next_irq;
      end
   end
endmodule

// ===== mbd_pkg.sv
// Constants, field layouts and types of the memory bank decoder
package mbd_pkg;
   localparam int NUM_BANKS = 4;

   // Fixed regions and bank windows
   localparam logic [31:0] PERIPH_BASE = 32'hFFF0_0000;
   localparam logic [31:0] RAM_BASE    = 32'hFFE0_0000;
   localparam logic [31:0] CACHE_TOP   = 32'h7FDF_FFFF;
   localparam logic [31:0] NC_BASE     = 32'h8000_0000;
   localparam logic [31:0] NC_TOP      = 32'hFFDF_FFFF;

   // Bank control register fields
   localparam int BASE_LSB   = 19;
   localparam int BASE_W     = 13;
   localparam int BASE_SHIFT = 18;
   localparam int SIZE_LSB   = 0;
   localparam int WIDTH_LSB  = 4;
   localparam int SDRAM_BIT  = 6;
   localparam int ENABLE_BIT = 7;
   localparam logic [3:0] SIZE_MAX_IO    = 4'h7;
   localparam logic [3:0] SIZE_MAX_SDRAM = 4'h8;
   localparam logic [1:0] WIDTH_8  = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;

   // Register offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_INFO   = 8'h08;
   localparam logic [7:0] OFS_BANK0  = 8'h10;

   // Status bits
   localparam int STAT_ABORT   = 0;
   localparam int STAT_OVERLAP = 1;
   localparam int STAT_DONE    = 2;
   localparam int STAT_W       = 3;

   // Reset values and cycle counts
   localparam logic [31:0]        BANK_RESET = 32'h0000_0000;
   localparam logic [STAT_W-1:0]  MASK_RESET = 3'h0;
   localparam logic [1:0]         STRAP_CAPTURE_CYCLE = 2'h2;
   localparam logic [1:0]         BEAT_HOLD_CYCLES    = 2'h3;

   typedef enum logic {ST_IDLE, ST_BEAT} mbd_state_t;
endpackage

// ===== mbd_lane_map.sv
// Byte lane steering between the big-endian core word and the external data lanes
module mbd_lane_map
   import mbd_pkg::*;
(
   input  wire logic [31:0] word_in,
   input  wire logic [31:0] ext_in,
   input  wire logic [1:0]  beat_in,
   input  wire logic [1:0]  width_in,
   input  wire logic        little_in,
   output logic      [31:0] ext_out,
   output logic      [31:0] merged_out
);
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         logic [2:0] lanes;
         logic [1:0] j;
         logic [1:0] offs;
         logic [1:0] src;
         logic [1:0] b;
         logic [1:0] woffs;
         logic [1:0] wlane;
         logic       in_beat;
         // Write side: external lane g takes one byte of the word when inside the width, else zero
         always_comb begin
            lanes = 3'(1) << width_in;
            j     = 2'(g);
            offs  = 2'(lanes - 3'(1)) - j;
            if (little_in) begin
               offs = j;
            end
            src = 2'(beat_in << width_in) + offs;
            if (3'(g) < lanes) begin
               ext_out[8*g +: 8] = word_in[31 - 8*src -: 8];
            end else begin
               ext_out[8*g +: 8] = 8'h00;
            end
         end
         // Read side: word byte g refilled from its lane when in this beat
         always_comb begin
            b       = 2'(g);
            in_beat = ((b >> width_in) == (beat_in & 2'(3'(4) >> width_in) - 2'h1)) ||
                      (width_in == WIDTH_32);
            woffs   = b - 2'(beat_in << width_in);
            wlane   = 2'((3'(1) << width_in) - 3'(1)) - woffs;
            if (little_in) begin
               wlane = woffs;
            end
            if (in_beat) begin
               merged_out[31 - 8*g -: 8] = ext_in[8*wlane +: 8];
            end else begin
               merged_out[31 - 8*g -: 8] = word_in[31 - 8*g -: 8];
            end
         end
      end
   endgenerate
endmodule

// ===== mbd_top_props.sv
// Port-level checks of the bank decoder
module mbd_top_props
   import mbd_pkg::*;
(
   input wire logic                 CLK_IN,
   input wire logic                 RESET_N_IN,
   input wire logic                 REQ_IN,
   input wire logic [31:0]          REQ_ADDR_IN,
   input wire logic                 BUSY_OUT,
   input wire logic                 DONE_OUT,
   input wire logic                 ABORT_OUT,
   input wire logic                 CACHEABLE_OUT,
   input wire logic                 PERIPH_SEL_OUT,
   input wire logic                 RAM_SEL_OUT,
   input wire logic [24:0]          EXT_ADDR_OUT,
   input wire logic [3:0]           EXT_BE_N_OUT,
   input wire logic [NUM_BANKS-1:0] EXT_CS_OUT,
   input wire logic                 EXT_WR_OUT,
   input wire logic                 EXT_RD_OUT,
   input wire logic                 EXT_DATA_OE_N_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   logic take;
   // Request accepted this edge
   assign take = REQ_IN && !BUSY_OUT;
   a_abort_with_done: assert property (ABORT_OUT |-> DONE_OUT)
      else $error("abort without done");
   a_done_pulse: assert property (DONE_OUT && !take |=> !DONE_OUT)
      else $error("done longer than one cycle");
   a_cache_half: assert property (take |=> CACHEABLE_OUT == !$past(REQ_ADDR_IN[31]))
      else $error("cacheable flag wrong");
   a_periph_fixed: assert property (take && REQ_ADDR_IN[31:20] == 12'hFFF
      |=> PERIPH_SEL_OUT && !RAM_SEL_OUT && DONE_OUT && !ABORT_OUT)
      else $error("peripheral region not decoded");
   a_ram_fixed: assert property (take && REQ_ADDR_IN[31:20] == 12'hFFE
      |=> RAM_SEL_OUT && !PERIPH_SEL_OUT && DONE_OUT && !ABORT_OUT)
      else $error("ram region not decoded");
   a_fixed_no_cs: assert property (take && REQ_ADDR_IN[31:21] == 11'h7FF |=> EXT_CS_OUT == '0)
      else $error("bank selected in fixed region");
   a_cs_onehot: assert property ($onehot0(EXT_CS_OUT))
      else $error("several banks selected");
   a_wr_beats16: assert property ($rose(EXT_WR_OUT) && EXT_BE_N_OUT == 4'hC
      |-> EXT_WR_OUT [*6] ##1 DONE_OUT)
      else $error("halfword beat sequence wrong");
   a_addr_step16: assert property ($rose(EXT_WR_OUT) && EXT_BE_N_OUT == 4'hC
      |-> ##3 EXT_ADDR_OUT == $past(EXT_ADDR_OUT, 3) + 25'h1)
      else $error("halfword address step wrong");
   a_oe_drive: assert property (EXT_DATA_OE_N_OUT == !EXT_WR_OUT
      && EXT_RD_OUT == (EXT_CS_OUT != '0 && !EXT_WR_OUT))
      else $error("data enable or read strobe wrong");
   c_abort: cover property (ABORT_OUT);
   c_periph: cover property (PERIPH_SEL_OUT && DONE_OUT);
   c_beats: cover property ($rose(EXT_WR_OUT));
endmodule

// ===== mbd_ext_mem.sv
// Small external memory on the bank data lanes
module mbd_ext_mem (
   input  wire logic        clk_in,
   input  wire logic        cs_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [24:0] addr_in,
   input  wire logic [31:0] wdata_in,
   output logic      [31:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [16];
   // Store on every write cycle, drive data only while read selected
   always_ff @(posedge clk_in) begin
      if (cs_in && wr_in) mem[addr_in[3:0]] <= wdata_in;
   end
   // Idle lanes show the inverted address so stale data never looks valid
   assign rdata_out = (cs_in && rd_in) ? mem[addr_in[3:0]] : ~{7'h00, addr_in};
endmodule

// ===== mbd_top_tb.sv
// Self-checking bench for the bank decoder
module mbd_top_tb;
   import mbd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, req, req_wr, strap, reg_wr, reg_rd;
   logic busy, done, abort, cacheable, psel, rsel, irq, oe_n, ext_wr, ext_rd;
   logic [31:0] req_addr, req_wdata, reg_wdata, reg_rdata, rdata, ext_wdata, ext_rdata;
   logic [7:0] reg_addr;
   logic [24:0] ext_addr;
   logic [3:0] be_n;
   logic [NUM_BANKS-1:0] cs;
   int n_fail = 0;
   int total_checks = 0;
   always #50 clk = ~clk;
   mbd_top uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_IN(req), .REQ_WRITE_IN(req_wr),
      .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata), .BUSY_OUT(busy), .DONE_OUT(done),
      .ABORT_OUT(abort), .RDATA_OUT(rdata), .CACHEABLE_OUT(cacheable), .PERIPH_SEL_OUT(psel),
      .RAM_SEL_OUT(rsel), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr),
      .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .IRQ_OUT(irq),
      .ENDIAN_STRAP_DATA_LINE_IN(strap), .EXT_ADDR_OUT(ext_addr), .EXT_WDATA_OUT(ext_wdata),
      .EXT_DATA_OE_N_OUT(oe_n), .EXT_RDATA_IN(ext_rdata), .EXT_BE_N_OUT(be_n),
      .EXT_CS_OUT(cs), .EXT_WR_OUT(ext_wr), .EXT_RD_OUT(ext_rd));
   mbd_ext_mem pt (.clk_in(clk), .cs_in(cs[0]), .wr_in(ext_wr), .rd_in(ext_rd),
      .addr_in(ext_addr), .wdata_in(ext_wdata), .rdata_out(ext_rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Reset with a strap level, then wait for ready
   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
      chk({31'h0, busy}, 32'h0);
   endtask
   task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask
   // One word access, returns in the done cycle
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= 1'b1;
      req_wr <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         if (done === 1'b1) break;
      end
      chk({31'h0, done}, 32'h1);
   endtask
   task automatic t_abort_irq();
      reg_w(OFS_MASK, 32'h1);
      acc(1'b0, 32'h0000_0010, 32'h0);
      chk({29'h0, abort, cacheable, irq}, 32'h7);
      reg_chk(OFS_STATUS, 32'h1);
      reg_w(OFS_STATUS, 32'h1);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      reg_chk(8'h40, 32'h0);
   endtask
   task automatic t_fixed();
      acc(1'b0, 32'hFFF0_0010, 32'h0);
      chk({29'h0, psel, rsel, abort}, 32'h4);
      acc(1'b1, 32'hFFE0_0000, 32'h1234_5678);
      chk({29'h0, psel, rsel, cacheable}, 32'h2);
   endtask
   // Bank0 at 256 KB, 16-bit then 32-bit, little-endian memory
   task automatic t_le16();
      reg_w(OFS_BANK0, 32'h0008_0090);
      acc(1'b1, 32'h0004_0004, 32'hAABB_CCDD);
      chk({16'h0, pt.mem[2][15:0]}, 32'hBBAA);
      chk({16'h0, pt.mem[3][15:0]}, 32'hDDCC);
      acc(1'b0, 32'h0004_0004, 32'h0);
      chk(rdata, 32'hAABB_CCDD);
      reg_chk(OFS_INFO, 32'h5);
      reg_w(OFS_BANK0, 32'h0008_00A0);
      acc(1'b1, 32'h0004_0000, 32'h1122_3344);
      chk(pt.mem[0], 32'h4433_2211);
      acc(1'b0, 32'h0004_0000, 32'h0);
      chk(rdata, 32'h1122_3344);
   endtask
   // Bank0 8-bit, big-endian after a second reset
   task automatic t_be8();
      do_reset(1'b0);
      reg_w(OFS_BANK0, 32'h0008_0080);
      acc(1'b1, 32'h0004_0008, 32'hAABB_CCDD);
      chk({24'h0, pt.mem[8][7:0]}, 32'hAA);
      chk({24'h0, pt.mem[11][7:0]}, 32'hDD);
      acc(1'b0, 32'h0004_0008, 32'h0);
      chk(rdata, 32'hAABB_CCDD);
      reg_chk(OFS_STATUS, 32'h4);
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {req, req_wr, strap, reg_wr, reg_rd} = 5'h0;
      {req_addr, req_wdata, reg_wdata, reg_addr} = 104'h0;
      do_reset(1'b1);
      t_abort_irq();
      t_fixed();
      t_le16();
      t_be8();
      test_done();
   end
   // Watchdog
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule
bind mbd_top mbd_top_props u_props (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .REQ_IN(REQ_IN),
   .REQ_ADDR_IN(REQ_ADDR_IN), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .ABORT_OUT(ABORT_OUT),
   .CACHEABLE_OUT(CACHEABLE_OUT), .PERIPH_SEL_OUT(PERIPH_SEL_OUT), .RAM_SEL_OUT(RAM_SEL_OUT),
   .EXT_ADDR_OUT(EXT_ADDR_OUT), .EXT_BE_N_OUT(EXT_BE_N_OUT), .EXT_CS_OUT(EXT_CS_OUT),
   .EXT_WR_OUT(EXT_WR_OUT), .EXT_RD_OUT(EXT_RD_OUT), .EXT_DATA_OE_N_OUT(EXT_DATA_OE_N_OUT));
